// file: cap_counter_array.sv
// Functional notes
// - Compare value sets how many counter clocks the output stays low per period.
// - Output goes high when counter equals the compare value.
// - Output goes low when the 16-bit counter overflows.
// - Wide mode needs compare enable, pulse width and wide width selects set.
// - With match flag enable, each compare match sets the module event flag.
// - Writing compare low byte clears compare enable.
// - Writing compare high byte sets compare enable.
// - High fraction is (65536 - compare) / 65536; zero gives always high.
// - Compare enable clear holds the output low.
// - Wrap flag, control bit 7, sets when counter rolls over to zero.
// - Wrap flag with wrap interrupt enabled requests the interrupt.
// - Flags are never cleared by hardware; software writes zero.
// - Run bit, control bit 6, stops or starts the counter.
// - Control bits 5 to 3 read zero and ignore writes.
// - Module event flags in bits 2 to 0 set on match.
// - Event flag with flag interrupt enabled requests the shared interrupt.
// - Control register at 0xD8, bit-addressable, resets to zero.
`include "cap_params.svh"
`default_nettype none

module cap_counter_array (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic sfr_bit_wr,
  input wire logic [2:0] sfr_bit_index,
  input wire logic sfr_bit_value,
  output logic [7:0] sfr_rdata,
  output logic counter_array_irq,
  output logic [2:0] module_output_pin
);

  localparam int NMOD = `CAP_NUM_MODULES;

  cap_pkg::cap_top_state_t st;
  cap_pkg::cap_top_state_t next_st;
  logic step;
  logic wrap;
  logic [15:0] cnt_next;
  logic ctrl_wr;
  logic ctrl_bit_wr;
  logic [NMOD-1:0] wr_mode;
  logic [NMOD-1:0] wr_low;
  logic [NMOD-1:0] wr_high;
  logic [NMOD-1:0] event_set;
  logic [NMOD-1:0] pin;
  logic [NMOD-1:0] fie;
  logic [7:0] mode [NMOD];
  logic [15:0] cmp [NMOD];
  logic [7:0] ctrl_image;
  logic [7:0] rd_value;
  logic [7:0] bit_image;

  // ----------------------------------------
  // Counter stepping
  // ----------------------------------------
  always_comb begin
    step = st.run;
    cnt_next = step ? 16'(st.cnt + 16'h0001) : st.cnt;
    wrap = step && (st.cnt == `CAP_CNT_MAX);
    ctrl_wr = sfr_wr && (sfr_addr == `CAP_CTRL_ADDR);
    ctrl_bit_wr = sfr_bit_wr && (sfr_addr == `CAP_CTRL_ADDR);
  end

  // ----------------------------------------
  // Compare modules
  // ----------------------------------------
  for (genvar i = 0; i < NMOD; i++) begin : g_mod
    assign wr_mode[i] = sfr_wr && (sfr_addr == 8'(`CAP_MODE_BASE + i));
    assign wr_low[i] = sfr_wr && (sfr_addr == 8'(`CAP_CPL_BASE + 2 * i));
    assign wr_high[i] = sfr_wr && (sfr_addr == 8'(`CAP_CPL_BASE + 2 * i + 1));
    assign fie[i] = mode[i][`CAP_MODE_FIE_BIT];
    cap_pwm_module u_mod (
      .mclk(mclk),
      .resetn(resetn),
      .wr_mode(wr_mode[i]),
      .wr_low(wr_low[i]),
      .wr_high(wr_high[i]),
      .wdata(sfr_wdata),
      .step(step),
      .wrap(wrap),
      .cnt_next(cnt_next),
      .pin(pin[i]),
      .event_set(event_set[i]),
      .mode(mode[i]),
      .cmp(cmp[i])
    );
  end

  // ----------------------------------------
  // Control image and read mux
  // ----------------------------------------
  always_comb begin
    ctrl_image = {st.wrap, st.run, 3'b000, st.flag};
    bit_image = ctrl_image;
    bit_image[sfr_bit_index] = sfr_bit_value;
    rd_value = 8'h00;
    if (sfr_addr == `CAP_CTRL_ADDR) begin
      rd_value = ctrl_image;
    end else if (sfr_addr == `CAP_ARRAY_MODE_ADDR) begin
      rd_value = {7'h00, st.wie};
    end else if (sfr_addr == `CAP_CNT_LOW_ADDR) begin
      rd_value = st.cnt[7:0];
    end else if (sfr_addr == `CAP_CNT_HIGH_ADDR) begin
      rd_value = st.cnt[15:8];
    end
    for (int k = 0; k < NMOD; k++) begin
      if (sfr_addr == 8'(`CAP_MODE_BASE + k)) begin
        rd_value = mode[k];
      end
      if (sfr_addr == 8'(`CAP_CPL_BASE + 2 * k)) begin
        rd_value = cmp[k][7:0];
      end
      if (sfr_addr == 8'(`CAP_CPL_BASE + 2 * k + 1)) begin
        rd_value = cmp[k][15:8];
      end
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.cnt = cnt_next;
    if (ctrl_wr) begin
      next_st.wrap = sfr_wdata[`CAP_CTRL_WRAP_BIT];
      next_st.run = sfr_wdata[`CAP_CTRL_RUN_BIT];
      next_st.flag = sfr_wdata[2:0];
    end else if (ctrl_bit_wr) begin
      next_st.wrap = bit_image[`CAP_CTRL_WRAP_BIT];
      next_st.run = bit_image[`CAP_CTRL_RUN_BIT];
      next_st.flag = bit_image[2:0];
    end
    if (sfr_wr && sfr_addr == `CAP_ARRAY_MODE_ADDR) begin
      next_st.wie = sfr_wdata[`CAP_ARRAY_WIE_BIT];
    end
    if (wrap) begin
      next_st.wrap = 1'b1;
    end
    next_st.flag = next_st.flag | event_set;
    next_st.irq = (next_st.wrap & next_st.wie)
      | (|(next_st.flag & fie));
    next_st.rdata = sfr_rd ? rd_value : st.rdata;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st <= '{cnt: `CAP_CNT_RESET, run: 1'b0, wrap: 1'b0, flag: 3'b000,
        wie: 1'b0, rdata: `CAP_CTRL_RESET, irq: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign sfr_rdata = st.rdata;
  assign counter_array_irq = st.irq;
  assign module_output_pin = pin;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_wrap_step;
    wrap ##1 st.wrap && st.cnt == `CAP_CNT_RESET;
  endsequence

  sequence s_flag_untouched;
    (st.wrap || st.flag != 3'b000) && !ctrl_wr && !ctrl_bit_wr;
  endsequence

  sequence s_ctrl_read;
    sfr_rd && sfr_addr == `CAP_CTRL_ADDR;
  endsequence

  sequence s_bit_run;
    ctrl_bit_wr && !sfr_wr && sfr_bit_index == 3'(`CAP_CTRL_RUN_BIT);
  endsequence

  a_wrap_sets_flag: assert property (@(posedge mclk) disable iff (!resetn)
    wrap |-> s_wrap_step)
    else $error("wrap flag not set on rollover");

  a_flags_held: assert property (@(posedge mclk) disable iff (!resetn)
    s_flag_untouched |=> st.wrap >= $past(st.wrap) && (st.flag & $past(st.flag)) == $past(st.flag))
    else $error("flag cleared by hardware");

  a_stop_holds_count: assert property (@(posedge mclk) disable iff (!resetn)
    !st.run |=> st.cnt == $past(st.cnt))
    else $error("counter moved while stopped");

  a_run_counts_up: assert property (@(posedge mclk) disable iff (!resetn)
    st.run |=> st.cnt == 16'($past(st.cnt) + 16'h0001))
    else $error("counter did not step by one");

  a_unused_read_zero: assert property (@(posedge mclk) disable iff (!resetn)
    s_ctrl_read |=> sfr_rdata[5:3] == 3'b000 && sfr_rdata[2:0] == $past(st.flag))
    else $error("unused control bits not zero");

  a_event_sets_flag: assert property (@(posedge mclk) disable iff (!resetn)
    event_set != 3'b000 |=> (st.flag & $past(event_set)) == $past(event_set))
    else $error("event flag not set");

  a_wrap_irq: assert property (@(posedge mclk) disable iff (!resetn)
    st.wrap && st.wie && $stable(st.wie) |-> counter_array_irq)
    else $error("wrap did not request interrupt");

  a_flag_irq: assert property (@(posedge mclk) disable iff (!resetn)
    (st.flag & fie) != 3'b000 && $stable(fie) |-> counter_array_irq)
    else $error("event flag did not request interrupt");

  a_reset_ctrl_zero: assert property (@(posedge mclk)
    $rose(resetn) |-> st.run == 1'b0 && st.wrap == 1'b0 && st.flag == 3'b000)
    else $error("control register not zero after reset");

  a_ctrl_read_map: assert property (@(posedge mclk) disable iff (!resetn)
    s_ctrl_read |=> sfr_rdata == {$past(st.wrap), $past(st.run), 3'b000, $past(st.flag)})
    else $error("control read does not match register");

  a_rdata_stands: assert property (@(posedge mclk) disable iff (!resetn)
    !sfr_rd |=> $stable(sfr_rdata))
    else $error("read data changed without a read");

  a_ctrl_write_run: assert property (@(posedge mclk) disable iff (!resetn)
    ctrl_wr |=> st.run == $past(sfr_wdata[`CAP_CTRL_RUN_BIT]))
    else $error("run bit not taken from byte write");

  a_bit_write_run: assert property (@(posedge mclk) disable iff (!resetn)
    s_bit_run |=> st.run == $past(sfr_bit_value))
    else $error("run bit not taken from bit write");

  a_bit_write_keeps: assert property (@(posedge mclk) disable iff (!resetn)
    ctrl_bit_wr && !sfr_wr && sfr_bit_index != 3'(`CAP_CTRL_RUN_BIT) |=> st.run == $past(st.run))
    else $error("bit write disturbed run bit");

  a_bit_write_wrap: assert property (@(posedge mclk) disable iff (!resetn)
    ctrl_bit_wr && !sfr_wr && sfr_bit_index == 3'(`CAP_CTRL_WRAP_BIT) && !wrap
      |=> st.wrap == $past(sfr_bit_value))
    else $error("wrap flag not taken from bit write");

  a_ctrl_write_wrap: assert property (@(posedge mclk) disable iff (!resetn)
    ctrl_wr && !wrap |=> st.wrap == $past(sfr_wdata[`CAP_CTRL_WRAP_BIT]))
    else $error("wrap flag not taken from byte write");

  a_flag_write: assert property (@(posedge mclk) disable iff (!resetn)
    ctrl_wr && event_set == 3'b000 |=> st.flag == $past(sfr_wdata[2:0]))
    else $error("event flags not taken from byte write");

  a_wrap_at_max: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(st.wrap) && !$past(ctrl_wr) && !$past(ctrl_bit_wr) |-> $past(wrap))
    else $error("wrap flag set without rollover");

  a_count_rolls_zero: assert property (@(posedge mclk) disable iff (!resetn)
    st.run && st.cnt == `CAP_CNT_MAX |=> st.cnt == `CAP_CNT_RESET)
    else $error("counter did not roll over to zero");

  a_irq_has_cause: assert property (@(posedge mclk) disable iff (!resetn)
    counter_array_irq |-> (st.wrap && st.wie) || (st.flag & $past(fie)) != 3'b000)
    else $error("interrupt without a set flag");

  a_flag_from_event: assert property (@(posedge mclk) disable iff (!resetn)
    !ctrl_wr && !ctrl_bit_wr |=> (st.flag & ~$past(st.flag) & ~$past(event_set)) == 3'b000)
    else $error("event flag set without a match");

  a_wie_write: assert property (@(posedge mclk) disable iff (!resetn)
    sfr_wr && sfr_addr == `CAP_ARRAY_MODE_ADDR |=> st.wie == $past(sfr_wdata[`CAP_ARRAY_WIE_BIT]))
    else $error("wrap interrupt enable not written");

  a_cnt_read_low: assert property (@(posedge mclk) disable iff (!resetn)
    sfr_rd && sfr_addr == `CAP_CNT_LOW_ADDR |=> sfr_rdata == $past(st.cnt[7:0]))
    else $error("counter low byte read wrong");

  a_cnt_read_high: assert property (@(posedge mclk) disable iff (!resetn)
    sfr_rd && sfr_addr == `CAP_CNT_HIGH_ADDR |=> sfr_rdata == $past(st.cnt[15:8]))
    else $error("counter high byte read wrong");

  a_reset_outputs: assert property (@(posedge mclk)
    $rose(resetn) |-> sfr_rdata == 8'h00 && !counter_array_irq && module_output_pin == 3'b000)
    else $error("outputs not cleared by reset");

  for (genvar j = 0; j < NMOD; j++) begin : g_chk
    a_pin_needs_wide: assert property (@(posedge mclk) disable iff (!resetn)
      !mode[j][`CAP_MODE_WIDE_BIT] || !mode[j][`CAP_MODE_PWSEL_BIT] |=> !pin[j])
      else $error("pin high outside wide mode");

    a_event_needs_enable: assert property (@(posedge mclk) disable iff (!resetn)
      event_set[j] |-> mode[j][`CAP_MODE_MATCH_BIT])
      else $error("event without match flag enable");

    a_event_at_rise: assert property (@(posedge mclk) disable iff (!resetn)
      event_set[j] |=> pin[j] && st.flag[j])
      else $error("event flag not paired with rising pin");

    a_rise_counts_low: assert property (@(posedge mclk) disable iff (!resetn)
      $rose(pin[j]) |-> st.cnt == $past(cmp[j]))
      else $error("pin rose at wrong count");

    a_mode_read: assert property (@(posedge mclk) disable iff (!resetn)
      sfr_rd && sfr_addr == 8'(`CAP_MODE_BASE + j) |=> sfr_rdata == $past(mode[j]))
      else $error("mode register read wrong");

    a_cmp_read: assert property (@(posedge mclk) disable iff (!resetn)
      sfr_rd && sfr_addr == 8'(`CAP_CPL_BASE + 2 * j) |=> sfr_rdata == $past(cmp[j][7:0]))
      else $error("compare low byte read wrong");
  end

endmodule : cap_counter_array

`default_nettype wire

// file: cap_params.svh
`ifndef CAP_PARAMS_SVH
`define CAP_PARAMS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define CAP_CTRL_ADDR 8'hd8
`define CAP_ARRAY_MODE_ADDR 8'hd9
`define CAP_MODE_BASE 8'hda
`define CAP_CPL_BASE 8'he9
`define CAP_CNT_LOW_ADDR 8'hf9
`define CAP_CNT_HIGH_ADDR 8'hfa

// ----------------------------------------
// Control and array mode register fields
// ----------------------------------------
`define CAP_CTRL_WRAP_BIT 7
`define CAP_CTRL_RUN_BIT 6
`define CAP_CTRL_RESET 8'h00
`define CAP_ARRAY_WIE_BIT 0

// ----------------------------------------
// Module mode register fields
// ----------------------------------------
`define CAP_MODE_WIDE_BIT 7
`define CAP_MODE_CMPEN_BIT 6
`define CAP_MODE_MATCH_BIT 3
`define CAP_MODE_PWSEL_BIT 1
`define CAP_MODE_FIE_BIT 0
`define CAP_MODE_RESET 8'h00

// ----------------------------------------
// Counter and module figures
// ----------------------------------------
`define CAP_NUM_MODULES 3
`define CAP_CNT_MAX 16'hffff
`define CAP_CNT_RESET 16'h0000
`define CAP_CMP_RESET 16'h0000

`endif

// file: cap_pkg.sv
`default_nettype none

package cap_pkg;

  // ----------------------------------------
  // State of one compare module
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] mode;
    logic [15:0] cmp;
    logic pin;
  } cap_mod_state_t;

  // ----------------------------------------
  // State of the shared counter and register
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] cnt;
    logic run;
    logic wrap;
    logic [2:0] flag;
    logic wie;
    logic [7:0] rdata;
    logic irq;
  } cap_top_state_t;

endpackage : cap_pkg

`default_nettype wire

// file: cap_pwm_module.sv
`include "cap_params.svh"
`default_nettype none

module cap_pwm_module (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic wr_mode,
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic [7:0] wdata,
  input wire logic step,
  input wire logic wrap,
  input wire logic [15:0] cnt_next,
  output logic pin,
  output logic event_set,
  output logic [7:0] mode,
  output logic [15:0] cmp
);

  cap_pkg::cap_mod_state_t st;
  cap_pkg::cap_mod_state_t next_st;
  logic wide;
  logic match;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    wide = st.mode[`CAP_MODE_CMPEN_BIT] & st.mode[`CAP_MODE_PWSEL_BIT]
      & st.mode[`CAP_MODE_WIDE_BIT];
    match = wide & step & (cnt_next == st.cmp);
    event_set = match & st.mode[`CAP_MODE_MATCH_BIT];
    if (wr_mode) begin
      next_st.mode = wdata;
    end
    if (wr_low) begin
      next_st.cmp[7:0] = wdata;
      next_st.mode[`CAP_MODE_CMPEN_BIT] = 1'b0;
    end
    if (wr_high) begin
      next_st.cmp[15:8] = wdata;
      next_st.mode[`CAP_MODE_CMPEN_BIT] = 1'b1;
    end
    if (!wide) begin
      next_st.pin = 1'b0;
    end else if (match) begin
      next_st.pin = 1'b1;
    end else if (wrap) begin
      next_st.pin = 1'b0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st <= '{mode: `CAP_MODE_RESET, cmp: `CAP_CMP_RESET, pin: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign pin = st.pin;
  assign mode = st.mode;
  assign cmp = st.cmp;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_match_drives_high: assert property (@(posedge mclk) disable iff (!resetn)
    match |=> st.pin)
    else $error("pin not high after match");

  a_wrap_drives_low: assert property (@(posedge mclk) disable iff (!resetn)
    wrap && !match |=> !st.pin)
    else $error("pin not low after wrap");

  a_disabled_holds_low: assert property (@(posedge mclk) disable iff (!resetn)
    !st.mode[`CAP_MODE_CMPEN_BIT] |=> !st.pin)
    else $error("pin high while compare disabled");

  a_low_write_disables: assert property (@(posedge mclk) disable iff (!resetn)
    wr_low && !wr_high |=> !st.mode[`CAP_MODE_CMPEN_BIT] && st.cmp[7:0] == $past(wdata))
    else $error("low byte write did not clear enable");

  a_high_write_enables: assert property (@(posedge mclk) disable iff (!resetn)
    wr_high |=> st.mode[`CAP_MODE_CMPEN_BIT] && st.cmp[15:8] == $past(wdata))
    else $error("high byte write did not set enable");

  a_rise_at_compare: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(st.pin) |-> $past(cnt_next) == $past(st.cmp) && $past(step))
    else $error("pin rose away from compare value");

endmodule : cap_pwm_module

`default_nettype wire

// file: cap_pwm_load.sv
`default_nettype none

module cap_pwm_load (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [2:0] pin,
  output logic [2:0] seen_high,
  output logic [15:0] low_len,
  output logic [15:0] high_len
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] low_run;
  logic [15:0] high_run;

  // ----------------------------------------
  // Load watch: high marks, low and high time of pin 0
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      seen_high <= 3'h0;
      low_run <= 16'h0000;
      low_len <= 16'h0000;
      high_run <= 16'h0000;
      high_len <= 16'h0000;
    end else begin
      seen_high <= seen_high | pin;
      if (pin[0]) begin
        if (low_run != 16'h0000) begin
          low_len <= low_run;
        end
        low_run <= 16'h0000;
        high_run <= high_run + 16'h0001;
      end else begin
        if (high_run != 16'h0000) begin
          high_len <= high_run;
        end
        high_run <= 16'h0000;
        low_run <= low_run + 16'h0001;
      end
    end
  end
endmodule : cap_pwm_load

`default_nettype wire

// file: tb.sv
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk, resetn, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_value, counter_array_irq;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [2:0] sfr_bit_index, module_output_pin, seen_high;
  logic [15:0] low_len, high_len, a, b;
  int n_fail, checked;

  cap_counter_array DUT (.mclk(mclk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_index(sfr_bit_index),
    .sfr_bit_value(sfr_bit_value), .sfr_rdata(sfr_rdata), .counter_array_irq(counter_array_irq),
    .module_output_pin(module_output_pin));
  cap_pwm_load load (.mclk(mclk), .resetn(resetn), .pin(module_output_pin), .seen_high(seen_high),
    .low_len(low_len), .high_len(high_len));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge mclk);
    #1;
    sfr_addr = ad;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge mclk);
    #1;
    sfr_wr = 1'b0;
  endtask : wr

  task automatic bw(input logic [2:0] idx, input logic v);
    @(posedge mclk);
    #1;
    sfr_addr = 8'hd8;
    sfr_bit_index = idx;
    sfr_bit_value = v;
    sfr_bit_wr = 1'b1;
    @(posedge mclk);
    #1;
    sfr_bit_wr = 1'b0;
  endtask : bw

  task automatic rd(input logic [7:0] ad, output logic [15:0] d);
    @(posedge mclk);
    #1;
    sfr_addr = ad;
    sfr_rd = 1'b1;
    @(posedge mclk);
    #1;
    sfr_rd = 1'b0;
    d = {8'h00, sfr_rdata};
  endtask : rd

  task automatic wait_pin(input int lv, input int lim);
    int i;
    for (i = 0; i < lim && module_output_pin[0] !== lv[0]; i++) begin
      @(posedge mclk);
      #1;
    end
    if (i == lim) begin
      n_fail++;
      $display("CHECK FAILED pin0 wait expected %0d seen %b", lv, module_output_pin[0]);
      stop_test();
    end
  endtask : wait_pin

  task automatic irq_is(input logic v);
    @(posedge mclk);
    #1;
    chk("irq", {15'h0000, v}, {15'h0000, counter_array_irq});
  endtask : irq_is

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_ctrl();
    rd(8'hd8, a);
    chk("ctrl reset", 16'h0000, a);
    wr(8'hd8, 8'hbf);
    rd(8'hd8, a);
    chk("ctrl unused bits", 16'h0087, a);
    irq_is(1'b0);
    wr(8'hd8, 8'h00);
    rd(8'hd8, a);
    chk("ctrl clear", 16'h0000, a);
    rd(8'h80, a);
    chk("unmapped", 16'h0000, a);
    rd(8'hf9, a);
    chk("count held", 16'h0000, a);
  endtask : t_ctrl

  task automatic t_cmp();
    wr(8'hda, 8'hcb);
    wr(8'he9, 8'h04);
    rd(8'hda, a);
    chk("mode0 low write", 16'h008b, a);
    wr(8'hea, 8'h00);
    rd(8'hda, a);
    chk("mode0 high write", 16'h00cb, a);
    wr(8'hdb, 8'h8a);
    wr(8'heb, 8'h01);
    wr(8'hdc, 8'h42);
    wr(8'hed, 8'h02);
    wr(8'hee, 8'h00);
    rd(8'hdc, a);
    chk("mode2", 16'h0042, a);
  endtask : t_cmp

  task automatic t_run();
    bw(3'h6, 1'b1);
    wait_pin(1, 20);
    rd(8'hd8, a);
    chk("match flag", 16'h0041, a);
    chk("irq flag", 16'h0001, {15'h0000, counter_array_irq});
    rd(8'hf9, a);
    rd(8'hf9, b);
    chk("count step", 16'h0002, b - a);
    wait_pin(0, 70000);
    rd(8'hd8, a);
    chk("wrap flag", 16'h00c1, a);
    chk("high time", 16'hfffc, high_len);
    wait_pin(1, 20);
    @(posedge mclk);
    #1;
    chk("low time", 16'h0004, low_len);
    chk("period", 16'h0000, 16'(low_len + high_len));
    chk("pins 2..1", 16'h0000, {14'h0000, seen_high[2:1]});
    chk("pin1 off", 16'h0000, {15'h0000, seen_high[1]});
  endtask : t_run

  task automatic t_irq();
    wr(8'hda, 8'hca);
    bw(3'h0, 1'b0);
    irq_is(1'b0);
    wr(8'hd9, 8'h01);
    irq_is(1'b1);
    bw(3'h7, 1'b0);
    irq_is(1'b0);
    bw(3'h6, 1'b0);
    rd(8'hf9, a);
    rd(8'hf9, b);
    chk("count stop", a, b);
    rd(8'hd8, a);
    chk("ctrl final", 16'h0000, a);
  endtask : t_irq

  initial begin
    n_fail = 0;
    checked = 0;
    resetn = 1'b0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_bit_wr = 1'b0;
    sfr_bit_value = 1'b0;
    sfr_bit_index = 3'h0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    repeat (4) @(posedge mclk);
    #1;
    resetn = 1'b1;
    t_ctrl();
    t_cmp();
    t_run();
    t_irq();
    stop_test();
  end
endmodule : tb

`default_nettype wire
